// file: rcl_pkg.sv
// Package: register map, field layout, reset values and types for the cal/loop block
package rcl_pkg;
    localparam logic [15:0] ADDR_CAL_CTRL = 16'hdf14;
    localparam logic [15:0] ADDR_FOC_CFG = 16'hdf15;
    localparam logic [15:0] ADDR_CLKREC_CFG = 16'hdf16;
    localparam logic [7:0] CAL_CTRL_RESET = 8'h04;
    localparam logic [7:0] FOC_CFG_RESET = 8'h76;
    localparam logic [7:0] CLKREC_CFG_RESET = 8'h6c;
    localparam logic [7:0] CAL_CTRL_MASK = 8'h3f;
    localparam logic [7:0] FOC_CFG_MASK = 8'h7f;
    localparam logic [7:0] CLKREC_CFG_MASK = 8'hff;
    localparam int CAL_MODE_LSB = 4;
    localparam int FOC_GATE_BIT = 5;
    localparam int FOC_PRE_LSB = 3;
    localparam int FOC_POST_BIT = 2;
    localparam int FOC_LIM_LSB = 0;
    localparam int CR_KI_LSB = 6;
    localparam int CR_KP_LSB = 4;
    localparam int CR_POST_KI_BIT = 3;
    localparam int CR_POST_KP_BIT = 2;
    localparam int CR_LIM_LSB = 0;
    localparam logic [1:0] CAL_NEVER = 2'h0;
    localparam logic [1:0] CAL_ON_START = 2'h1;
    localparam logic [1:0] CAL_ON_RETURN = 2'h2;
    localparam logic [1:0] CAL_EVERY_4TH = 2'h3;
    localparam logic [1:0] RETURN_COUNT_LAST = 2'h3;

    // Gain codes: multiples of K in half-K units (K = 2)
    typedef logic [3:0] rcl_gain_t;
    localparam rcl_gain_t GAIN_HALF_K = 4'h1;
    localparam rcl_gain_t GAIN_ONE_K = 4'h2;

    typedef enum logic [1:0] {
        RCL_IDLE,
        RCL_RX,
        RCL_TX,
        RCL_SYNTH_ON_TX_READY_STATE
    } rcl_radio_e;

    typedef struct packed {
        logic run;
        rcl_gain_t gain_a;
        rcl_gain_t gain_b;
        logic [1:0] limit;
    } rcl_loop_s;
endpackage : rcl_pkg

// file: rcl_loop_ctrl.sv
// One tracking loop's gain, limit and freeze selection
`timescale 1ns/100ps
module rcl_loop_ctrl
    import rcl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] pre_a_in,
    input wire logic [1:0] pre_b_in,
    input wire logic post_a_in,
    input wire logic post_b_in,
    input wire logic post_b_halves_in,
    input wire logic [1:0] limit_in,
    input wire logic synced_in,
    input wire logic frozen_in,
    output rcl_loop_s loop_out
);
    rcl_gain_t pre_a;
    rcl_gain_t pre_b;
    rcl_loop_s loop_next;

    // Pre-sync gain: code n gives (n+1) K
    assign pre_a = rcl_gain_t'({2'h0, pre_a_in} + 4'h1) << 1;
    assign pre_b = rcl_gain_t'({2'h0, pre_b_in} + 4'h1) << 1;

    always_comb begin
        loop_next.run = !frozen_in && (limit_in != 2'h0);
        loop_next.limit = limit_in;
        loop_next.gain_a = (synced_in && post_a_in) ? GAIN_HALF_K : pre_a;
        if (synced_in && post_b_in) begin
            loop_next.gain_b = post_b_halves_in ? GAIN_HALF_K : GAIN_ONE_K;
        end else begin
            loop_next.gain_b = pre_b;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            loop_out <= '0;
        end else begin
            loop_out <= loop_next;
        end
    end
endmodule : rcl_loop_ctrl

// file: rcl_cal_loop.sv
// Top: synth calibration scheduling and tracking loop configuration
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module rcl_cal_loop
    import rcl_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic SRST_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    input wire logic CAL_STROBE_IN,
    input wire logic [1:0] RADIO_STATE_IN,
    input wire logic AUTO_RETURN_IN,
    input wire logic CARRIER_SENSE_IN,
    input wire logic SYNC_FOUND_IN,
    input wire logic SEARCH_START_IN,
    output logic CAL_START_OUT,
    output logic [3:0] RETURN_COUNT_OUT,
    output rcl_loop_s FREQ_LOOP_OUT,
    output rcl_loop_s CLKREC_LOOP_OUT
);
    logic [7:0] cal_ctrl_reg;
    logic [7:0] foc_cfg_reg;
    logic [7:0] clkrec_cfg_reg;
    logic [1:0] prev_state_reg;
    logic [1:0] return_cnt_reg;
    logic synced_reg;
    logic carrier_seen_reg;
    logic frozen;
    logic leave_idle;
    logic cal_next;
    logic [1:0] cal_mode;

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            cal_ctrl_reg <= CAL_CTRL_RESET;
            foc_cfg_reg <= FOC_CFG_RESET;
            clkrec_cfg_reg <= CLKREC_CFG_RESET;
        end else if (WR_IN) begin
            // Bit 6 is stored as written except at ADDR_CAL_CTRL, whose mask clears it; FOC_CFG_RESET and CLKREC_CFG_RESET set it to one
            case (ADDR_IN)
                ADDR_CAL_CTRL: cal_ctrl_reg <= WDATA_IN & CAL_CTRL_MASK;
                ADDR_FOC_CFG: foc_cfg_reg <= WDATA_IN & FOC_CFG_MASK;
                ADDR_CLKREC_CFG: clkrec_cfg_reg <= WDATA_IN & CLKREC_CFG_MASK;
                default: ;
            endcase
        end
    end

    // Read data one cycle later; unmapped reads zero
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (RD_IN) begin
            case (ADDR_IN)
                ADDR_CAL_CTRL: RDATA_OUT <= cal_ctrl_reg;
                ADDR_FOC_CFG: RDATA_OUT <= foc_cfg_reg;
                ADDR_CLKREC_CFG: RDATA_OUT <= clkrec_cfg_reg;
                default: RDATA_OUT <= 8'h00;
            endcase
        end else begin
            RDATA_OUT <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration scheduling
    assign cal_mode = cal_ctrl_reg[CAL_MODE_LSB +: 2];
    assign leave_idle = (prev_state_reg == RCL_IDLE) && (RADIO_STATE_IN != RCL_IDLE);

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            prev_state_reg <= RCL_IDLE;
        end else begin
            prev_state_reg <= RADIO_STATE_IN;
        end
    end

    // Counts automatic returns in CAL_EVERY_4TH mode only, held at zero otherwise; wraps after the fourth
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            return_cnt_reg <= 2'h0;
        end else if (cal_mode != CAL_EVERY_4TH) begin
            return_cnt_reg <= 2'h0;
        end else if (AUTO_RETURN_IN) begin
            return_cnt_reg <= return_cnt_reg + 2'h1;
        end
    end

    always_comb begin
        cal_next = CAL_STROBE_IN;
        case (cal_mode)
            CAL_NEVER: cal_next = CAL_STROBE_IN;
            CAL_ON_START: cal_next = CAL_STROBE_IN || leave_idle;
            CAL_ON_RETURN: cal_next = CAL_STROBE_IN || AUTO_RETURN_IN;
            CAL_EVERY_4TH: begin
                cal_next = CAL_STROBE_IN
                    || (AUTO_RETURN_IN && return_cnt_reg == RETURN_COUNT_LAST);
            end
            default: cal_next = CAL_STROBE_IN;
        endcase
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            CAL_START_OUT <= 1'b0;
            RETURN_COUNT_OUT <= 4'h0;
        end else begin
            CAL_START_OUT <= cal_next;
            RETURN_COUNT_OUT <= {2'h0, return_cnt_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sync and carrier tracking; a sync seen beside a search start is kept
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            synced_reg <= 1'b0;
        end else if (SYNC_FOUND_IN) begin
            synced_reg <= 1'b1;
        end else if (SEARCH_START_IN) begin
            synced_reg <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            carrier_seen_reg <= 1'b0;
        end else if (CARRIER_SENSE_IN) begin
            carrier_seen_reg <= 1'b1;
        end else if (SEARCH_START_IN) begin
            carrier_seen_reg <= 1'b0;
        end
    end

    assign frozen = foc_cfg_reg[FOC_GATE_BIT] && !carrier_seen_reg && !CARRIER_SENSE_IN;

    ////////////////////////////////////////////////////////////////////////
    // Loop controls: frequency uses gain_a only; clock recovery a=KI, b=KP
    rcl_loop_ctrl u_freq (
        .clk_in(REF_CLK_IN),
        .rst_in(SRST_IN),
        .pre_a_in(foc_cfg_reg[FOC_PRE_LSB +: 2]),
        .pre_b_in(2'h0),
        .post_a_in(foc_cfg_reg[FOC_POST_BIT]),
        .post_b_in(1'b0),
        .post_b_halves_in(1'b0),
        .limit_in(foc_cfg_reg[FOC_LIM_LSB +: 2]),
        .synced_in(synced_reg),
        .frozen_in(frozen),
        .loop_out(FREQ_LOOP_OUT)
    );

    rcl_loop_ctrl u_clkrec (
        .clk_in(REF_CLK_IN),
        .rst_in(SRST_IN),
        .pre_a_in(clkrec_cfg_reg[CR_KI_LSB +: 2]),
        .pre_b_in(clkrec_cfg_reg[CR_KP_LSB +: 2]),
        .post_a_in(clkrec_cfg_reg[CR_POST_KI_BIT]),
        .post_b_in(clkrec_cfg_reg[CR_POST_KP_BIT]),
        .post_b_halves_in(1'b0),
        .limit_in(clkrec_cfg_reg[CR_LIM_LSB +: 2]),
        .synced_in(synced_reg),
        .frozen_in(frozen),
        .loop_out(CLKREC_LOOP_OUT)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_never_auto;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (cal_mode == CAL_NEVER && !CAL_STROBE_IN) |=> !CAL_START_OUT;
    endproperty
    a_never_auto: assert property (p_never_auto) else $error("auto cal in mode 00");

    property p_start_cal;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (cal_mode == CAL_ON_START && leave_idle) |=> CAL_START_OUT;
    endproperty
    a_start_cal: assert property (p_start_cal) else $error("no cal leaving idle");

    property p_return_cal;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (cal_mode == CAL_ON_RETURN && AUTO_RETURN_IN) |=> CAL_START_OUT;
    endproperty
    a_return_cal: assert property (p_return_cal) else $error("no cal on return");

    property p_fourth;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (cal_mode == CAL_EVERY_4TH && AUTO_RETURN_IN && !CAL_STROBE_IN)
            |=> (CAL_START_OUT == ($past(return_cnt_reg) == RETURN_COUNT_LAST));
    endproperty
    a_fourth: assert property (p_fourth) else $error("wrong fourth-return cal");

    property p_nibble;
        @(posedge REF_CLK_IN) $past(SRST_IN) |-> cal_ctrl_reg[3:0] == 4'h4;
    endproperty
    a_nibble: assert property (p_nibble) else $error("cal nibble reset wrong");

    property p_freeze;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        frozen |=> !FREQ_LOOP_OUT.run && !CLKREC_LOOP_OUT.run;
    endproperty
    a_freeze: assert property (p_freeze) else $error("loop ran while gated");

    property p_freq_post;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (synced_reg && foc_cfg_reg[FOC_POST_BIT]) |=> FREQ_LOOP_OUT.gain_a == GAIN_HALF_K;
    endproperty
    a_freq_post: assert property (p_freq_post) else $error("freq post gain wrong");

    property p_kp_post;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (synced_reg && clkrec_cfg_reg[CR_POST_KP_BIT]) |=> CLKREC_LOOP_OUT.gain_b == GAIN_ONE_K;
    endproperty
    a_kp_post: assert property (p_kp_post) else $error("KP post gain wrong");

    property p_search;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (SEARCH_START_IN && !SYNC_FOUND_IN) |=> !synced_reg ##1 (FREQ_LOOP_OUT.gain_a
            == (rcl_gain_t'({2'h0, $past(foc_cfg_reg[FOC_PRE_LSB +: 2])} + 4'h1) << 1));
    endproperty
    a_search: assert property (p_search) else $error("no pre-sync after search");

    property p_limit_off;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (clkrec_cfg_reg[CR_LIM_LSB +: 2] == 2'h0) |=> !CLKREC_LOOP_OUT.run;
    endproperty
    a_limit_off: assert property (p_limit_off) else $error("rate comp not off");

    property p_freq_pre;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        !synced_reg |=> FREQ_LOOP_OUT.gain_a
            == rcl_gain_t'({1'b0, $past(foc_cfg_reg[FOC_PRE_LSB +: 2]), 1'b0} + 4'h2);
    endproperty
    a_freq_pre: assert property (p_freq_pre) else $error("freq pre gain wrong");

    property p_freq_same;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (synced_reg && !foc_cfg_reg[FOC_POST_BIT]) |=> FREQ_LOOP_OUT.gain_a
            == rcl_gain_t'({1'b0, $past(foc_cfg_reg[FOC_PRE_LSB +: 2]), 1'b0} + 4'h2);
    endproperty
    a_freq_same: assert property (p_freq_same) else $error("freq post same wrong");

    property p_freq_off;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (foc_cfg_reg[FOC_LIM_LSB +: 2] == 2'h0) |=> !FREQ_LOOP_OUT.run;
    endproperty
    a_freq_off: assert property (p_freq_off) else $error("freq comp not off");

    property p_freq_limit;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        1'b1 |=> FREQ_LOOP_OUT.limit == $past(foc_cfg_reg[FOC_LIM_LSB +: 2]);
    endproperty
    a_freq_limit: assert property (p_freq_limit) else $error("freq limit wrong");

    property p_ki_pre;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        !synced_reg |=> CLKREC_LOOP_OUT.gain_a
            == rcl_gain_t'({1'b0, $past(clkrec_cfg_reg[CR_KI_LSB +: 2]), 1'b0} + 4'h2);
    endproperty
    a_ki_pre: assert property (p_ki_pre) else $error("KI pre gain wrong");

    property p_kp_pre;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        !synced_reg |=> CLKREC_LOOP_OUT.gain_b
            == rcl_gain_t'({1'b0, $past(clkrec_cfg_reg[CR_KP_LSB +: 2]), 1'b0} + 4'h2);
    endproperty
    a_kp_pre: assert property (p_kp_pre) else $error("KP pre gain wrong");

    property p_ki_post;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (synced_reg && clkrec_cfg_reg[CR_POST_KI_BIT]) |=> CLKREC_LOOP_OUT.gain_a == GAIN_HALF_K;
    endproperty
    a_ki_post: assert property (p_ki_post) else $error("KI post gain wrong");

    property p_rate_limit;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        1'b1 |=> CLKREC_LOOP_OUT.limit == $past(clkrec_cfg_reg[CR_LIM_LSB +: 2]);
    endproperty
    a_rate_limit: assert property (p_rate_limit) else $error("rate limit wrong");

    property p_gate_open;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        (!foc_cfg_reg[FOC_GATE_BIT] && clkrec_cfg_reg[CR_LIM_LSB +: 2] != 2'h0)
            |=> CLKREC_LOOP_OUT.run;
    endproperty
    a_gate_open: assert property (p_gate_open) else $error("loop idle without gate");

    property p_sync;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        SYNC_FOUND_IN |=> synced_reg;
    endproperty
    a_sync: assert property (p_sync) else $error("sync not taken");

    property p_strobe;
        @(posedge REF_CLK_IN) disable iff (SRST_IN)
        CAL_STROBE_IN |=> CAL_START_OUT;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe did not calibrate");
endmodule : rcl_cal_loop

// file: testbench.sv
// Self-checking testbench for the calibration scheduling and loop configuration block
`timescale 1ns/100ps
module testbench
    import rcl_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cal_stb = 1'b0;
    logic [1:0] state = 2'h0;
    logic auto_ret = 1'b0;
    logic cs = 1'b0;
    logic sync = 1'b0;
    logic search = 1'b0;
    logic [7:0] rdata;
    logic cal_start;
    logic [3:0] ret_cnt;
    rcl_loop_s freq_loop;
    rcl_loop_s cr_loop;
    int n_fail = 0;
    int compares = 0;
    // Bench copy of the configuration and loop status
    logic [7:0] foc_v = 8'h76;
    logic [7:0] cr_v = 8'h6c;
    logic synced_v = 1'b0;
    logic cs_seen_v = 1'b0;

    rcl_cal_loop dut (.REF_CLK_IN(clk), .SRST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CAL_STROBE_IN(cal_stb),
        .RADIO_STATE_IN(state), .AUTO_RETURN_IN(auto_ret), .CARRIER_SENSE_IN(cs),
        .SYNC_FOUND_IN(sync), .SEARCH_START_IN(search), .CAL_START_OUT(cal_start),
        .RETURN_COUNT_OUT(ret_cnt), .FREQ_LOOP_OUT(freq_loop), .CLKREC_LOOP_OUT(cr_loop));

    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // Sample just past the edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : reg_rd

    // One-cycle pulse: 0 cal, 1 return, 2 sync, 3 search, 4 carrier
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: cal_stb <= 1'b1;
            1: auto_ret <= 1'b1;
            2: sync <= 1'b1;
            3: search <= 1'b1;
            default: cs <= 1'b1;
        endcase
        @(posedge clk);
        {cal_stb, auto_ret, sync, search, cs} <= 5'h00;
        #1;
        if (k == 2) synced_v = 1'b1;
        if (k == 3) {synced_v, cs_seen_v} = 2'h0;
        if (k == 4) cs_seen_v = 1'b1;
    endtask : pulse

    task automatic go(input int s, input logic exp);
        @(posedge clk);
        state <= 2'(s);
        tick(1);
        check(cal_start, exp);
    endtask : go

    // Gains in half units, so code n maps to 2*(n+1)
    function automatic rcl_loop_s exp_loop(input logic is_freq);
        rcl_loop_s e;
        if (is_freq) begin
            e.gain_a = (synced_v && foc_v[2]) ? 4'h1 : {1'b0, foc_v[4:3], 1'b0} + 4'h2;
            e.gain_b = 4'h2;
            e.limit = foc_v[1:0];
        end else begin
            e.gain_a = (synced_v && cr_v[3]) ? 4'h1 : {1'b0, cr_v[7:6], 1'b0} + 4'h2;
            e.gain_b = (synced_v && cr_v[2]) ? 4'h2 : {1'b0, cr_v[5:4], 1'b0} + 4'h2;
            e.limit = cr_v[1:0];
        end
        e.run = !(foc_v[5] && !cs_seen_v) && (e.limit != 2'h0);
        return e;
    endfunction : exp_loop

    task automatic chk_loops;
        tick(2);
        check({5'h00, freq_loop}, {5'h00, exp_loop(1'b1)});
        check({5'h00, cr_loop}, {5'h00, exp_loop(1'b0)});
    endtask : chk_loops

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        reg_rd(16'hdf14, 8'h04);
        tick(1);
        check(rdata, 8'h00);
        reg_rd(16'hdf15, 8'h76);
        reg_rd(16'hdf16, 8'h6c);
        chk_loops();
        reg_wr(16'hdf14, 8'hc4);
        reg_rd(16'hdf14, 8'h04);
        reg_wr(16'hdf17, 8'hff);
        reg_rd(16'hdf17, 8'h00);
        // Mode 00: only the strobe calibrates
        pulse(0);
        check(cal_start, 1'b1);
        go(1, 1'b0);
        pulse(1);
        check(cal_start, 1'b0);
        go(0, 1'b0);
        reg_wr(16'hdf14, 8'h14);
        for (int s = 1; s < 4; s++) begin
            go(s, 1'b1);
            go(0, 1'b0);
        end
        pulse(1);
        check(cal_start, 1'b0);
        reg_wr(16'hdf14, 8'h24);
        go(2, 1'b0);
        pulse(1);
        check(cal_start, 1'b1);
        tick(1);
        check(cal_start, 1'b0);
        go(0, 1'b0);
        // Five returns: wraps after the fourth, leaves the count nonzero
        reg_wr(16'hdf14, 8'h34);
        for (int i = 0; i < 5; i++) begin
            pulse(1);
            check(cal_start, (i % 4) == 3);
            tick(1);
            check(ret_cnt, 4'((i + 1) % 4));
        end
        reg_wr(16'hdf14, 8'h04);
        tick(2);
        check(ret_cnt, 4'h0);
        // Every gain and limit code, both post-sync choices
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                foc_v = {3'h0, 2'(c), 1'(p), 2'(c)};
                cr_v = {2'(c), ~2'(c), 1'(p), 1'(p), 2'(c)};
                reg_wr(16'hdf15, foc_v);
                reg_wr(16'hdf16, cr_v);
                chk_loops();
                pulse(2);
                chk_loops();
                pulse(3);
                chk_loops();
            end
        end
        reg_rd(16'hdf16, cr_v);
        // Gate on: frozen until carrier, refrozen by a new search
        foc_v = 8'h36;
        cr_v = 8'h6e;
        reg_wr(16'hdf15, foc_v);
        reg_wr(16'hdf16, cr_v);
        chk_loops();
        pulse(4);
        chk_loops();
        pulse(3);
        chk_loops();
        final_report();
    end

    // Run needs well under 1000 cycles
    initial begin
        #1000000;
        n_fail++;
        final_report();
    end
endmodule : testbench
